/* File: spi_host_model.sv */
// host model: serial master driving select, clock and data in mode 3
// assumes clk is the 40 MHz bench clock; half a serial period is 4 clk
`timescale 1ns/10ps
module spi_host_model (
	// system
	input wire logic clk,
	// link
	output logic sel_n,
	output logic sck,
	output logic mosi,
	input wire logic miso
);
	initial begin
		sel_n = 1'b1;
		sck = 1'b1;
		mosi = 1'b1;
	end
	// n below 5 ends the frame early; unsent bits of rx stay z
	task automatic frame(input logic [39:0] tx, input int n, output logic [39:0] rx);
		rx = {40{1'bz}};
		@(posedge clk) sel_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 39; i >= 40 - 8 * n; i--) begin
			@(posedge clk) sck <= 1'b0;
			mosi <= tx[i];
			if (i == 20) repeat (50) @(posedge clk);
			repeat (4) @(posedge clk);
			rx[i] = miso;
			sck <= 1'b1;
			repeat (3) @(posedge clk);
		end
		@(posedge clk) sel_n <= 1'b1;
		mosi <= ~mosi;
		repeat (4) @(posedge clk);
	endtask
endmodule

/* File: spi_word_ram_access_slave.sv */
// serial slave port giving a host single-word access to a 64 x 24 word RAM
// assumes link pins are asynchronous and sampled by clk; serial clock far below clk
//
// Operation
// - device is only a slave; host supplies clock and select
// - select is active low; traffic ignored while select is high
// - mode 3: serial clock idles high
// - sample input on rising serial edge, change output on falling edge
// - every byte shifts most significant bit first
// - word address is six bits; only 64 words decoded
// - clock pauses of any length tolerated while select stays low
// - read: output high-impedance for bytes 0 and 1, then word msb first
// - words are 24 bits moved as three bytes, most significant first
// - output never driven during a write frame
`timescale 1ns/10ps
module spi_word_ram_access_slave #(
	parameter int RAM_WORDS = spi_word_ram_pkg::RAM_DEPTH
) (
	// system
	input wire logic clk,
	input wire logic reset_n,
	// serial link pins
	input wire logic slave_select_n,
	input wire logic serial_clk_pin,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic serial_out_oe,
	// status
	output logic frame_active,
	output logic write_done
);
	localparam int AW = spi_word_ram_pkg::ADDR_WIDTH;
	localparam int WW = spi_word_ram_pkg::WORD_WIDTH;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CMD = 4'b0010,
		ST_DATA = 4'b0100,
		ST_SKIP = 4'b1000
	} phase_type;

	logic [1:0] ss_sync;
	logic [1:0] sck_sync;
	logic [1:0] sdi_sync;
	logic sck_prev;
	logic [WW-1:0] ram [RAM_WORDS];
	phase_type phase;
	logic [2:0] bit_cnt;
	logic [2:0] byte_cnt;
	logic [7:0] shift_in;
	logic [AW-1:0] addr;
	logic is_write;
	logic [WW-1:0] out_word;

	wire selected = !ss_sync[1];
	wire sck_rise = selected && sck_sync[1] && !sck_prev;
	wire sck_fall = selected && !sck_sync[1] && sck_prev;
	wire byte_end = sck_rise && bit_cnt == 3'h7;
	wire [7:0] next_byte = {shift_in[6:0], sdi_sync[1]};

	// two-flop synchronisers; the link clock is sampled, not used as a clock
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ss_sync <= 2'h3;
			sck_sync <= 2'h3;
			sdi_sync <= 2'h0;
			sck_prev <= 1'b1;
		end else begin
			ss_sync <= {ss_sync[0], slave_select_n};
			sck_sync <= {sck_sync[0], serial_clk_pin};
			sdi_sync <= {sdi_sync[0], serial_in_pin};
			sck_prev <= sck_sync[1];
		end
	end

	// bit and byte position; only edges move it, so pauses just hold it
	always_ff @(posedge clk) begin
		if (!reset_n || !selected) begin
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
			shift_in <= 8'h00;
		end else if (sck_rise) begin
			shift_in <= next_byte;
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7 && byte_cnt != spi_word_ram_pkg::FRAME_BYTES)
				byte_cnt <= byte_cnt + 3'h1;
		end
	end

	// frame phase and command decode
	always_ff @(posedge clk) begin
		if (!reset_n || !selected) begin
			phase <= ST_IDLE;
			addr <= '0;
			is_write <= 1'b0;
		end else begin
			case (phase)
				ST_IDLE: begin
					phase <= ST_CMD;
				end
				ST_CMD: begin
					if (byte_end && byte_cnt == 3'h0 && next_byte != spi_word_ram_pkg::CMD_ACCESS)
						phase <= ST_SKIP;
					if (byte_end && byte_cnt == 3'h1) begin
						addr <= next_byte[spi_word_ram_pkg::ADDR_LSB +: AW];
						if (next_byte[1:0] == spi_word_ram_pkg::OP_WRITE) begin
							is_write <= 1'b1;
							phase <= ST_DATA;
						end else if (next_byte[1:0] == spi_word_ram_pkg::OP_READ) begin
							phase <= ST_DATA;
						end else begin
							phase <= ST_SKIP;
						end
					end
				end
				ST_DATA: begin
					if (byte_end && byte_cnt == 3'h4)
						phase <= ST_SKIP;
				end
				ST_SKIP: begin
					phase <= ST_SKIP;
				end
				default: begin
					phase <= ST_IDLE;
				end
			endcase
		end
	end

	// write data collects msb first; ram word changes only on the last byte
	logic [15:0] wr_hold;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_hold <= 16'h0000;
			write_done <= 1'b0;
		end else begin
			write_done <= 1'b0;
			if (phase == ST_DATA && is_write && byte_end) begin
				wr_hold <= {wr_hold[7:0], next_byte};
				if (byte_cnt == 3'h4) begin
					ram[addr] <= {wr_hold, next_byte};
					write_done <= 1'b1;
				end
			end
		end
	end

	// read output: word loaded after the address byte, shifted on falling edges
	always_ff @(posedge clk) begin
		if (!reset_n || !selected) begin
			out_word <= spi_word_ram_pkg::RAM_RESET;
			serial_out_pin <= 1'b1;
			serial_out_oe <= 1'b0;
		end else if (phase == ST_DATA && !is_write && byte_cnt >= spi_word_ram_pkg::FIRST_DATA_BYTE
				&& byte_cnt < spi_word_ram_pkg::FRAME_BYTES) begin
			if (sck_fall) begin
				serial_out_oe <= 1'b1;
				serial_out_pin <= out_word[WW-1];
				out_word <= {out_word[WW-2:0], 1'b0};
			end
		end else begin
			serial_out_oe <= 1'b0;
			if (phase == ST_CMD && byte_end && byte_cnt == 3'h1)
				out_word <= ram[next_byte[spi_word_ram_pkg::ADDR_LSB +: AW]];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			frame_active <= 1'b0;
		else
			frame_active <= selected;
	end

	a_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n)
		ss_sync[1] |=> !serial_out_oe)
		else $error("output enabled while deselected");
	a_write_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
		is_write |-> !serial_out_oe)
		else $error("output driven during write");
	a_hiz_early: assert property (@(posedge clk) disable iff (!reset_n)
		byte_cnt < 3'h2 |-> !serial_out_oe)
		else $error("output driven in command bytes");
	a_write_late: assert property (@(posedge clk) disable iff (!reset_n)
		write_done |-> $past(byte_cnt) == 3'h4 && $past(is_write))
		else $error("write before last data byte");
	a_drive_on_fall: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(serial_out_oe) |-> $past(sck_fall))
		else $error("output started off a falling edge");
	a_byte_cap: assert property (@(posedge clk) disable iff (!reset_n)
		byte_cnt <= spi_word_ram_pkg::FRAME_BYTES)
		else $error("byte counter overran");
	a_pause_holds: assert property (@(posedge clk) disable iff (!reset_n)
		selected && !sck_rise |=> $stable(bit_cnt) || !selected)
		else $error("position moved without a clock edge");
	a_abort_idle: assert property (@(posedge clk) disable iff (!reset_n)
		!selected |=> phase == ST_IDLE && !write_done)
		else $error("frame not discarded on deselect");

	// multi-step checks: a refused command goes quiet, the last write byte commits
	sequence s_cmd_refused;
		phase == ST_CMD && byte_end && byte_cnt == 3'h0
			&& next_byte != spi_word_ram_pkg::CMD_ACCESS;
	endsequence
	sequence s_last_write_byte;
		phase == ST_DATA && is_write && byte_end && byte_cnt == 3'h4;
	endsequence
	a_refused_quiet: assert property (@(posedge clk) disable iff (!reset_n)
		s_cmd_refused |=> phase == ST_SKIP ##1 !serial_out_oe)
		else $error("refused command did not silence the frame");
	a_commit_last: assert property (@(posedge clk) disable iff (!reset_n)
		s_last_write_byte |=> write_done)
		else $error("write not committed after last data byte");
	a_done_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		write_done |=> !write_done)
		else $error("write pulse longer than one cycle");
endmodule

/* File: spi_word_ram_pkg.sv */
// constants for the serial word-RAM access port
// assumes a single 40 MHz system clock; link pins are asynchronous to it
package spi_word_ram_pkg;
	localparam int ADDR_WIDTH = 6;
	localparam int WORD_WIDTH = 24;
	localparam int RAM_DEPTH = 64;
	localparam logic [7:0] CMD_ACCESS = 8'h01;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h2;
	localparam int OP_LSB = 0;
	localparam int ADDR_LSB = 2;
	localparam logic [2:0] FRAME_BYTES = 3'h5;
	localparam logic [2:0] FIRST_DATA_BYTE = 3'h2;
	localparam logic [WORD_WIDTH-1:0] RAM_RESET = 24'h00_0000;
	localparam int CLK_PERIOD_NS = 25;
endpackage

/* File: tb_top.sv */
// testbench: word writes, read back, aborted write, refused commands
// assumes the host model drives the link; output is seen as z when not enabled
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic sel_n, sck, mosi, pin, oe, active, done;
	int fails = 0;
	int n_compared = 0;
	int n_wr = 0;
	int n_act = 0;
	localparam logic [39:0] ZZ = {40{1'bz}};
	wire miso = oe ? pin : 1'bz;
	always #12.5 clk = ~clk;
	always @(posedge clk) if (done === 1'b1) n_wr <= n_wr + 1;
	always @(posedge clk) if (done === 1'b1 && active === 1'b1) n_act <= n_act + 1;
	spi_host_model host (.clk(clk), .sel_n(sel_n), .sck(sck), .mosi(mosi), .miso(miso));
	spi_word_ram_access_slave dut (.clk(clk), .reset_n(reset_n), .slave_select_n(sel_n),
		.serial_clk_pin(sck), .serial_in_pin(mosi), .serial_out_pin(pin),
		.serial_out_oe(oe), .frame_active(active), .write_done(done));
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (fails == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic xf(input logic [7:0] c, input logic [5:0] a, input logic [1:0] op,
		input logic [23:0] d, input int n, input logic [39:0] exp);
		logic [39:0] rx;
		host.frame({c, a, op, d}, n, rx);
		check(rx, exp);
		check(40'({oe, active}), 40'h0);
	endtask
	task automatic t_write_read;
		xf(8'h01, 6'h3f, 2'h2, 24'ha5_5ac3, 5, ZZ);
		xf(8'h01, 6'h00, 2'h2, 24'h12_3456, 5, ZZ);
		xf(8'h01, 6'h3f, 2'h0, 24'h00_0000, 5, {ZZ[39:24], 24'ha5_5ac3});
		xf(8'h01, 6'h00, 2'h0, 24'h00_0000, 5, {ZZ[39:24], 24'h12_3456});
		check(40'(n_wr), 40'h2);
		check(40'(n_act), 40'h2);
	endtask
	task automatic t_abort;
		xf(8'h01, 6'h3f, 2'h2, 24'hff_ffff, 4, ZZ);
		xf(8'h01, 6'h3f, 2'h0, 24'h00_0000, 5, {ZZ[39:24], 24'ha5_5ac3});
		check(40'(n_wr), 40'h2);
	endtask
	task automatic t_bad_cmd;
		xf(8'h02, 6'h00, 2'h2, 24'hff_ffff, 5, ZZ);
		xf(8'h01, 6'h00, 2'h1, 24'hff_ffff, 5, ZZ);
		xf(8'h01, 6'h00, 2'h0, 24'h00_0000, 5, {ZZ[39:24], 24'h12_3456});
		check(40'(n_wr), 40'h2);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		#1 check(40'({oe, active, done}), 40'h0);
		repeat (3) @(posedge clk);
		t_write_read();
		t_abort();
		t_bad_cmd();
		end_sim();
	end
	// frames take about 400 clk each; the nine of this test fit well inside this span
	initial begin
		#500000;
		fails++;
		end_sim();
	end
endmodule
